// File: include/tcr_pkg.sv
// Package: offsets, field positions and constants of the trace unit configuration registers
package tcr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets on the debug register interface
    localparam logic [11:0] OFF_AUX = 12'h018;
    localparam logic [11:0] OFF_CCNT = 12'h038;
    localparam logic [11:0] OFF_BBC = 12'h03C;
    localparam logic [11:0] OFF_RLDV0 = 12'h140;
    localparam logic [11:0] OFF_CNTCTL0 = 12'h150;
    localparam logic [11:0] OFF_CNTV0 = 12'h160;
    localparam logic [11:0] OFF_CIDV_LO = 12'h600;
    localparam logic [11:0] OFF_CIDV_HI = 12'h604;
    localparam logic [11:0] OFF_CIDMASK = 12'h680;
    localparam logic [11:0] OFF_CLAIMSET = 12'hFA0;
    localparam logic [11:0] OFF_CLAIMCLR = 12'hFA4;
    localparam logic [11:0] OFF_CID0 = 12'hFF0;
    localparam logic [11:0] OFF_CID1 = 12'hFF4;
    localparam logic [11:0] OFF_CID2 = 12'hFF8;
    localparam logic [11:0] OFF_CID3 = 12'hFFC;
    // Auxiliary control fields
    localparam int AUX_FLUSH_RDY_BIT = 0;
    localparam int AUX_IDLE_ACK_BIT = 1;
    localparam int AUX_W = 2;
    // Branch broadcast fields, cycle count, context mask and claim widths
    localparam int BB_MODE_BIT = 8;
    localparam int BB_RANGE_W = 8;
    localparam int CCNT_W = 12;
    localparam int CID_MASK_W = 4;
    localparam int CLAIM_W = 4;
    localparam logic [3:0] CLAIM_IMPL = 4'hF;
    // Counter control 0 fields
    localparam int CC_RLD_SELF_BIT = 16;
    localparam int CC_RLD_KIND_BIT = 15;
    localparam int CC_RLD_PICK_LSB = 8;
    localparam int CC_CNT_KIND_BIT = 7;
    localparam int CC_CNT_PICK_LSB = 0;
    localparam logic [31:0] CC_WR_MASK = 32'h0001_8F8F;
    localparam int CNT_W = 16;
    localparam int RES_N = 16;
    localparam int PAIR_N = 8;
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [11:0] RST_CCNT = 12'h000;
endpackage : tcr_pkg

// File: verilog/tcr_counter0.sv
// Counter 0: resource selection, decrement and reload
module tcr_counter0
    import tcr_pkg::*;
#(
    parameter int CW = tcr_pkg::CNT_W
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [tcr_pkg::RES_N-1:0] res_i,
    input wire logic [tcr_pkg::PAIR_N-1:0] pair_i,
    input wire logic reload_on_zero_i,
    input wire logic reload_source_kind_i,
    input wire logic [3:0] reload_source_pick_i,
    input wire logic count_source_kind_i,
    input wire logic [3:0] count_source_pick_i,
    input wire logic [CW-1:0] reload_value_i,
    output logic [CW-1:0] count_o,
    output logic reload_o
);
    import tcr_pkg::*;

    // Kind 0 picks one of 16 singles, kind 1 one of 8 pairs
    function automatic logic pick_res(input logic kind, input logic [3:0] sel,
                                      input logic [RES_N-1:0] r, input logic [PAIR_N-1:0] p);
        pick_res = kind ? p[sel[2:0]] : r[sel];
    endfunction

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    wire logic cnt_act = pick_res(count_source_kind_i, count_source_pick_i, res_i, pair_i);
    wire logic rld_act = pick_res(reload_source_kind_i, reload_source_pick_i, res_i, pair_i);
    wire logic zero_hit = reload_on_zero_i && (cnt_ff == '0) && cnt_act;
    wire logic do_reload = rld_act || zero_hit;

    // Reload takes priority over the decrement; the counter saturates at zero
    assign nxt_cnt = do_reload ? reload_value_i :
                     (cnt_act && cnt_ff != '0) ? cnt_ff - CW'(1) : cnt_ff;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign count_o = cnt_ff;
    assign reload_o = do_reload;
endmodule // tcr_counter0

// File: verilog/tcr_regs.sv
// Trace unit configuration register bank with debug and memory-mapped ports
module tcr_regs
    import tcr_pkg::*;
#(
    parameter logic [7:0] PREAMBLE_ZERO = 8'h11,  // Arbitrary identification value
    parameter logic [3:0] PREAMBLE_ONE = 4'h2,    // Arbitrary identification value
    parameter logic [3:0] COMPONENT_CLASS = 4'h3, // Arbitrary identification value
    parameter logic [7:0] PREAMBLE_TWO = 8'h44,   // Arbitrary identification value
    parameter logic [7:0] PREAMBLE_THREE = 8'h55  // Arbitrary identification value
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    // External debug register interface
    input wire logic dbg_sel_i,
    input wire logic dbg_wr_i,
    input wire logic [tcr_pkg::ADDR_W-1:0] dbg_addr_i,
    input wire logic [tcr_pkg::DATA_W-1:0] dbg_wdata_i,
    output logic [tcr_pkg::DATA_W-1:0] dbg_rdata_o,
    // Internal memory-mapped port, reaches auxiliary control only
    input wire logic mm_sel_i,
    input wire logic mm_wr_i,
    input wire logic [tcr_pkg::ADDR_W-1:0] mm_addr_i,
    input wire logic [tcr_pkg::DATA_W-1:0] mm_wdata_i,
    output logic [tcr_pkg::DATA_W-1:0] mm_rdata_o,
    // Trace unit status
    input wire logic unit_idle_i,
    input wire logic flush_drained_i,
    input wire logic in_range_i,
    input wire logic [tcr_pkg::RES_N-1:0] res_i,
    input wire logic [tcr_pkg::PAIR_N-1:0] pair_i,
    // Outputs to the trace unit
    output logic idle_ack_o,
    output logic flush_ready_out_o,
    output logic [tcr_pkg::BB_RANGE_W-1:0] bb_range_o,
    output logic bb_include_o,
    output logic bb_active_o,
    output logic [tcr_pkg::CCNT_W-1:0] cc_threshold_o,
    output logic [31:0] ctx_value_o,
    output logic [tcr_pkg::CID_MASK_W-1:0] ctx_byte_mask_o,
    output logic [tcr_pkg::CLAIM_W-1:0] claim_o,
    output logic [tcr_pkg::CNT_W-1:0] count0_o,
    output logic reload0_o
);
    import tcr_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    wire logic dbg_we = dbg_sel_i && dbg_wr_i;
    wire logic mm_we = mm_sel_i && mm_wr_i;
    wire logic we_aux_dbg = dbg_we && hit(dbg_addr_i, OFF_AUX);
    wire logic we_aux_mm = mm_we && hit(mm_addr_i, OFF_AUX);
    wire logic we_ccnt = dbg_we && hit(dbg_addr_i, OFF_CCNT);
    wire logic we_bbc = dbg_we && hit(dbg_addr_i, OFF_BBC);
    wire logic we_rldv = dbg_we && hit(dbg_addr_i, OFF_RLDV0);
    wire logic we_cntctl = dbg_we && hit(dbg_addr_i, OFF_CNTCTL0);
    wire logic we_cidv = dbg_we && hit(dbg_addr_i, OFF_CIDV_LO);
    wire logic we_cidm = dbg_we && hit(dbg_addr_i, OFF_CIDMASK);
    wire logic we_cset = dbg_we && hit(dbg_addr_i, OFF_CLAIMSET);
    wire logic we_cclr = dbg_we && hit(dbg_addr_i, OFF_CLAIMCLR);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [AUX_W-1:0] aux_ff;
    logic [AUX_W-1:0] nxt_aux;
    logic [CCNT_W-1:0] ccnt_ff;
    logic [BB_MODE_BIT:0] bbc_ff;
    logic [CNT_W-1:0] rldv_ff;
    logic [31:0] cntctl_ff;
    logic [31:0] cidv_ff;
    logic [CID_MASK_W-1:0] cidm_ff;
    logic [CLAIM_W-1:0] claim_ff;
    logic [CLAIM_W-1:0] nxt_claim;
    logic [DATA_W-1:0] dbg_rdata_ff;
    logic [DATA_W-1:0] mm_rdata_ff;
    logic [DATA_W-1:0] dbg_rd_mux;

    // Debug write wins if both ports write the same cycle
    assign nxt_aux = we_aux_dbg ? dbg_wdata_i[AUX_W-1:0] :
                     we_aux_mm ? mm_wdata_i[AUX_W-1:0] : aux_ff;

    assign nxt_claim = we_cset ? (claim_ff | (dbg_wdata_i[CLAIM_W-1:0] & CLAIM_IMPL)) :
                       we_cclr ? (claim_ff & ~dbg_wdata_i[CLAIM_W-1:0]) : claim_ff;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux_ff <= '0;
            claim_ff <= '0;
        end else begin
            aux_ff <= nxt_aux;
            claim_ff <= nxt_claim;
        end
    end

    // Only implemented bits are stored, so reserved bits drop writes
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ccnt_ff <= RST_CCNT;
            bbc_ff <= '0;
            rldv_ff <= '0;
            cntctl_ff <= RST_ZERO;
            cidv_ff <= RST_ZERO;
            cidm_ff <= '0;
        end else begin
            if (we_ccnt) ccnt_ff <= dbg_wdata_i[CCNT_W-1:0];
            if (we_bbc) bbc_ff <= dbg_wdata_i[BB_MODE_BIT:0];
            if (we_rldv) rldv_ff <= dbg_wdata_i[CNT_W-1:0];
            if (we_cntctl) cntctl_ff <= dbg_wdata_i & CC_WR_MASK;
            if (we_cidv) cidv_ff <= dbg_wdata_i;
            if (we_cidm) cidm_ff <= dbg_wdata_i[CID_MASK_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Counter 0
    // ------------------------------------------------------------------
    tcr_counter0 #(
        .CW(CNT_W)
    ) u_counter0 (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .res_i(res_i),
        .pair_i(pair_i),
        .reload_on_zero_i(cntctl_ff[CC_RLD_SELF_BIT]),
        .reload_source_kind_i(cntctl_ff[CC_RLD_KIND_BIT]),
        .reload_source_pick_i(cntctl_ff[CC_RLD_PICK_LSB+:4]),
        .count_source_kind_i(cntctl_ff[CC_CNT_KIND_BIT]),
        .count_source_pick_i(cntctl_ff[CC_CNT_PICK_LSB+:4]),
        .reload_value_i(rldv_ff),
        .count_o(count0_o),
        .reload_o(reload0_o)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        dbg_rd_mux = '0;
        unique case (dbg_addr_i)
            OFF_AUX: dbg_rd_mux = {{(DATA_W-AUX_W){1'b0}}, aux_ff};
            OFF_CCNT: dbg_rd_mux = {{(DATA_W-CCNT_W){1'b0}}, ccnt_ff};
            OFF_BBC: dbg_rd_mux = {{(DATA_W-BB_MODE_BIT-1){1'b0}}, bbc_ff};
            OFF_RLDV0: dbg_rd_mux = {{(DATA_W-CNT_W){1'b0}}, rldv_ff};
            OFF_CNTCTL0: dbg_rd_mux = cntctl_ff;
            OFF_CNTV0: dbg_rd_mux = {{(DATA_W-CNT_W){1'b0}}, count0_o};
            OFF_CIDV_LO: dbg_rd_mux = cidv_ff;
            OFF_CIDV_HI: dbg_rd_mux = RST_ZERO;
            OFF_CIDMASK: dbg_rd_mux = {{(DATA_W-CID_MASK_W){1'b0}}, cidm_ff};
            OFF_CLAIMSET: dbg_rd_mux = {{(DATA_W-CLAIM_W){1'b0}}, CLAIM_IMPL};
            OFF_CLAIMCLR: dbg_rd_mux = {{(DATA_W-CLAIM_W){1'b0}}, claim_ff};
            OFF_CID0: dbg_rd_mux = {24'h000000, PREAMBLE_ZERO};
            OFF_CID1: dbg_rd_mux = {24'h000000, COMPONENT_CLASS, PREAMBLE_ONE};
            OFF_CID2: dbg_rd_mux = {24'h000000, PREAMBLE_TWO};
            OFF_CID3: dbg_rd_mux = {24'h000000, PREAMBLE_THREE};
            default: dbg_rd_mux = '0;
        endcase
    end

    // Read data registered one cycle after the select
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dbg_rdata_ff <= '0;
            mm_rdata_ff <= '0;
        end else begin
            dbg_rdata_ff <= (dbg_sel_i && !dbg_wr_i) ? dbg_rd_mux : '0;
            mm_rdata_ff <= (mm_sel_i && !mm_wr_i && hit(mm_addr_i, OFF_AUX)) ?
                           {{(DATA_W-AUX_W){1'b0}}, aux_ff} : '0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    wire logic any_range = |bbc_ff[BB_RANGE_W-1:0];

    assign dbg_rdata_o = dbg_rdata_ff;
    assign mm_rdata_o = mm_rdata_ff;
    assign idle_ack_o = aux_ff[AUX_IDLE_ACK_BIT] || unit_idle_i;
    assign flush_ready_out_o = aux_ff[AUX_FLUSH_RDY_BIT] || unit_idle_i || flush_drained_i;
    assign bb_range_o = bbc_ff[BB_RANGE_W-1:0];
    assign bb_include_o = bbc_ff[BB_MODE_BIT];
    // Include mode with no range is unpredictable; here it simply never broadcasts
    assign bb_active_o = bbc_ff[BB_MODE_BIT] ? (any_range && in_range_i) :
                         (!any_range || !in_range_i);
    assign cc_threshold_o = ccnt_ff;
    assign ctx_value_o = cidv_ff;
    assign ctx_byte_mask_o = cidm_ff;
    assign claim_o = claim_ff;
endmodule // tcr_regs

// File: testbench/tcr_regs_chk.sv
// Port-level assertions for the register bank
module tcr_regs_chk
    import tcr_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic dbg_sel_i,
    input wire logic dbg_wr_i,
    input wire logic [tcr_pkg::ADDR_W-1:0] dbg_addr_i,
    input wire logic [tcr_pkg::DATA_W-1:0] dbg_wdata_i,
    input wire logic [tcr_pkg::DATA_W-1:0] dbg_rdata_o,
    input wire logic unit_idle_i,
    input wire logic flush_drained_i,
    input wire logic in_range_i,
    input wire logic idle_ack_o,
    input wire logic flush_ready_out_o,
    input wire logic [tcr_pkg::BB_RANGE_W-1:0] bb_range_o,
    input wire logic bb_include_o,
    input wire logic bb_active_o,
    input wire logic [tcr_pkg::CCNT_W-1:0] cc_threshold_o,
    input wire logic [tcr_pkg::CLAIM_W-1:0] claim_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic rd;
    logic wr;
    assign rd = dbg_sel_i && !dbg_wr_i;
    assign wr = dbg_sel_i && dbg_wr_i;
    property p_idle; unit_idle_i |-> idle_ack_o; endproperty
    a_idle: assert property (p_idle) else $error("idle ack low while idle");
    property p_flush; unit_idle_i || flush_drained_i |-> flush_ready_out_o; endproperty
    a_flush: assert property (p_flush) else $error("flush ready low");
    property p_range; bb_range_o != 8'h00 |-> bb_active_o == (bb_include_o ~^ in_range_i); endproperty
    a_range: assert property (p_range) else $error("broadcast wrong for range");
    property p_whole; !bb_include_o && bb_range_o == 8'h00 |-> bb_active_o; endproperty
    a_whole: assert property (p_whole) else $error("broadcast off with no range");
    property p_ccnt; wr && dbg_addr_i == OFF_CCNT |=> cc_threshold_o == 12'($past(dbg_wdata_i)); endproperty
    a_ccnt: assert property (p_ccnt) else $error("threshold not written");
    property p_hi; rd && dbg_addr_i == OFF_CIDV_HI |=> dbg_rdata_o == 32'h0000_0000; endproperty
    a_hi: assert property (p_hi) else $error("upper compare word not zero");
    property p_cid; rd && dbg_addr_i >= OFF_CID0 |=> dbg_rdata_o[31:8] == 24'h000000; endproperty
    a_cid: assert property (p_cid) else $error("preamble upper bits set");
    property p_cset; wr && dbg_addr_i == OFF_CLAIMSET |=> claim_o == ($past(claim_o) | 4'($past(dbg_wdata_i))); endproperty
    a_cset: assert property (p_cset) else $error("claim set wrong");
    property p_cclr; wr && dbg_addr_i == OFF_CLAIMCLR |=> claim_o == ($past(claim_o) & ~4'($past(dbg_wdata_i))); endproperty
    a_cclr: assert property (p_cclr) else $error("claim clear wrong");
    property p_impl; rd && dbg_addr_i == OFF_CLAIMSET |=> dbg_rdata_o == {28'h0000000, CLAIM_IMPL}; endproperty
    a_impl: assert property (p_impl) else $error("claim mask wrong");
    c_claim: cover property (wr && dbg_addr_i == OFF_CLAIMCLR);
    c_incl: cover property (bb_include_o && bb_active_o);
    c_force: cover property (idle_ack_o && !unit_idle_i);
endmodule // tcr_regs_chk

bind tcr_regs tcr_regs_chk tcr_regs_chk_i (.clock_i, .nrst_i, .dbg_sel_i, .dbg_wr_i, .dbg_addr_i, .dbg_wdata_i,
    .dbg_rdata_o, .unit_idle_i, .flush_drained_i, .in_range_i, .idle_ack_o, .flush_ready_out_o, .bb_range_o,
    .bb_include_o, .bb_active_o, .cc_threshold_o, .claim_o);

// File: testbench/tcr_dbg_host.sv
// Register access host model for one port of the bank
module tcr_dbg_host (
    input wire logic clock_i,
    output logic sel_o,
    output logic wr_o,
    output logic [11:0] addr_o,
    output logic [31:0] wdata_o,
    input wire logic [31:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 12'h000;
        wdata_o = 32'h0000_0000;
    end
    // Idle bus shows the inverse of the last access, never a stale copy
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(negedge clock_i);
        sel_o = 1'b1;
        wr_o = wr;
        addr_o = a;
        wdata_o = d;
        @(negedge clock_i);
        q = rdata_i;
        sel_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // tcr_dbg_host

// File: testbench/testbench.sv
// Self-checking bench for the trace unit configuration register bank
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;
    // Identification values are arbitrary
    localparam logic [7:0] ID0 = 8'h3C;
    localparam logic [3:0] ID1 = 4'h6;
    localparam logic [3:0] CLS = 4'hA;
    localparam logic [7:0] ID2 = 8'h7E;
    localparam logic [7:0] ID3 = 8'h2B;
    logic clock_i, nrst_i, dbg_sel_i, dbg_wr_i, mm_sel_i, mm_wr_i, unit_idle_i, flush_drained_i, in_range_i;
    logic [11:0] dbg_addr_i, mm_addr_i, cc_threshold_o;
    logic [31:0] dbg_wdata_i, mm_wdata_i, dbg_rdata_o, mm_rdata_o, ctx_value_o, q, d;
    logic [15:0] res_i, count0_o;
    logic [7:0] pair_i, bb_range_o;
    logic idle_ack_o, flush_ready_out_o, bb_include_o, bb_active_o, reload0_o, act_c, rel, ck, rk;
    logic [3:0] ctx_byte_mask_o, claim_o, mclaim, cp, rp;
    logic [11:0] madr [9];
    logic [31:0] mmask [9], mval [9], ids [4];
    int num_errors = 0, samples_checked = 0, mcnt = 0;
    integer seed = 32'hBC6E908F;
    tcr_regs #(.PREAMBLE_ZERO(ID0), .PREAMBLE_ONE(ID1), .COMPONENT_CLASS(CLS), .PREAMBLE_TWO(ID2),
        .PREAMBLE_THREE(ID3)) tcr_regs_i (.*);
    tcr_dbg_host dbg_i (.clock_i(clock_i), .sel_o(dbg_sel_i), .wr_o(dbg_wr_i), .addr_o(dbg_addr_i),
        .wdata_o(dbg_wdata_i), .rdata_i(dbg_rdata_o));
    tcr_dbg_host mm_i (.clock_i(clock_i), .sel_o(mm_sel_i), .wr_o(mm_wr_i), .addr_o(mm_addr_i),
        .wdata_o(mm_wdata_i), .rdata_i(mm_rdata_o));
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        repeat (100000) @(posedge clock_i);
        num_errors++;
        $display("[FAIL] watchdog expected end seen timeout");
        complete_run();
    end
    initial begin
        {nrst_i, unit_idle_i, flush_drained_i, in_range_i, res_i, pair_i} = '0;
        madr = '{OFF_AUX, OFF_CCNT, OFF_BBC, OFF_RLDV0, OFF_CNTCTL0, OFF_CIDV_LO, OFF_CIDV_HI, OFF_CIDMASK, 12'h100};
        mmask = '{32'h3, 32'hFFF, 32'h1FF, 32'hFFFF, CC_WR_MASK, 32'hFFFF_FFFF, 32'h0, 32'hF, 32'h0};
        mval = '{default: 32'h0};
        ids = '{{24'h0, ID0}, {24'h0, CLS, ID1}, {24'h0, ID2}, {24'h0, ID3}};
        repeat (10) @(negedge clock_i);
        nrst_i = 1'b1;
        // Pass zero checks reset values, later passes random write and read back
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 9; i++) begin
                if (p > 0) begin
                    d = $random(seed);
                    dbg_i.xfer(1'b1, madr[i], d, q);
                    mval[i] = d & mmask[i];
                end
                dbg_i.xfer(1'b0, madr[i], 32'h0, q);
                check("reg_read", mval[i], q);
            end
        end
        check("cc_threshold", mval[1], cc_threshold_o);
        check("bb_fields", mval[2], {bb_include_o, bb_range_o});
        check("ctx_value", mval[5], ctx_value_o);
        check("ctx_mask", mval[7], ctx_byte_mask_o);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            dbg_i.xfer(1'b1, OFF_CID0 + 12'(k * 4), 32'hFFFF_FFFF, q);
            dbg_i.xfer(1'b0, OFF_CID0 + 12'(k * 4), 32'h0, q);
            check("preamble", ids[k], q);
        end
        $display("test preamble done");
        mclaim = 4'h0;
        for (int k = 0; k < 6; k++) begin
            d = $random(seed);
            dbg_i.xfer(1'b1, k[0] ? OFF_CLAIMCLR : OFF_CLAIMSET, d, q);
            mclaim = k[0] ? mclaim & ~d[3:0] : mclaim | d[3:0];
            dbg_i.xfer(1'b0, OFF_CLAIMCLR, 32'h0, q);
            check("claim_read", mclaim, q);
            check("claim_out", mclaim, claim_o);
            dbg_i.xfer(1'b0, OFF_CLAIMSET, 32'h0, q);
            check("claim_impl", 32'hF, q);
        end
        $display("test claim done");
        for (int c = 0; c < 16; c++) begin
            if (c[0])
                mm_i.xfer(1'b1, OFF_AUX, c, q);
            else
                dbg_i.xfer(1'b1, OFF_AUX, c, q);
            unit_idle_i = c[2];
            flush_drained_i = c[3];
            mm_i.xfer(1'b0, OFF_AUX, 32'h0, q);
            check("aux_mm", c & 3, q);
            dbg_i.xfer(1'b0, OFF_AUX, 32'h0, q);
            check("aux_dbg", c & 3, q);
            check("idle_ack", c[1] | c[2], idle_ack_o);
            check("flush_ready", c[0] | c[2] | c[3], flush_ready_out_o);
        end
        mm_i.xfer(1'b0, OFF_CCNT, 32'h0, q);
        check("mm_unmapped", 32'h0, q);
        $display("test aux done");
        for (int c = 0; c < 8; c++) begin
            d = c[1] ? (($random(seed) & 32'hFF) | 32'h1) : 32'h0;
            d[8] = c[0];
            dbg_i.xfer(1'b1, OFF_BBC, d, q);
            in_range_i = c[2];
            @(negedge clock_i);
            check("bb_active", d[7:0] == 8'h0 ? !c[0] : c[0] == c[2], bb_active_o);
        end
        $display("test broadcast done");
        dbg_i.xfer(1'b1, OFF_RLDV0, 32'hABCD_0005, q);
        for (int s = 1; s >= 0; s--) begin
            cp = $random(seed);
            rp = $random(seed);
            // Each pass picks single resources or combined pairs at random, once per selector
            ck = $random(seed);
            rk = $random(seed);
            dbg_i.xfer(1'b1, OFF_CNTCTL0, {15'h0, s[0], rk, 3'h0, rp, ck, 3'h0, cp}, q);
            for (int n = 0; n < 40; n++) begin
                res_i = $random(seed);
                pair_i = $random(seed);
                act_c = ck ? pair_i[cp[2:0]] : res_i[cp];
                rel = (rk ? pair_i[rp[2:0]] : res_i[rp]) || (s[0] && mcnt == 0 && act_c);
                #2;
                check("reload_pulse", rel, reload0_o);
                mcnt = rel ? 5 : (act_c && mcnt != 0) ? mcnt - 1 : mcnt;
                @(negedge clock_i);
                check("count_value", mcnt, count0_o);
            end
            res_i = 16'h0;
        end
        dbg_i.xfer(1'b0, OFF_CNTV0, 32'h0, q);
        check("count_read", mcnt, q);
        $display("test counter done");
        complete_run();
    end
endmodule // testbench
